// >>> verilog/iod_io_space.sv
// iod_io_space: I/O space decoder and register bank seen by the processor core.
// assumes: one core access per cycle; peripherals outside answer on the ext port
// in the same cycle, and raise ext_hit_i for addresses they own.
//
// Summary of operation
// - bit set and bit clear reach any I/O register at I/O address 0x00..0x1F.
// - skip-on-bit tests read one selected bit of a low-range I/O register.
// - some status flags clear on writing one; writing zero leaves them.
// - bit set or clear writes only the addressed bit, leaving other flags alone.
// - I/O-specific in and out address the 64 locations 0x00..0x3F.
// - load and store reach each I/O register at its I/O address plus 0x20.
// - extended registers 0x60..0xFF are reachable only by load and store.
`timescale 1ns/10ps
`default_nettype none
module iod_io_space
	import iod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// io path
	input wire logic io_re_i,
	input wire logic io_we_i,
	input wire logic [5:0] io_addr_i,
	// data-space path
	input wire logic ds_re_i,
	input wire logic ds_we_i,
	input wire logic [7:0] ds_addr_i,
	input wire logic [7:0] wdata_i,
	// bit path
	input wire logic bit_set_instr_i,
	input wire logic bit_clear_instr_i,
	input wire logic skip_if_bit_set_instr_i,
	input wire logic skip_if_bit_clear_instr_i,
	input wire logic [4:0] bit_addr_i,
	input wire logic [2:0] bit_sel_i,
	// answers to the core
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic skip_o,
	output logic skip_valid_o,
	// peripherals outside the bank
	output logic [7:0] ext_addr_o,
	output logic ext_re_o,
	output logic ext_we_o,
	output logic [7:0] ext_wdata_o,
	output logic [7:0] ext_wmask_o,
	input wire logic ext_hit_i,
	input wire logic [7:0] ext_rdata_i,
	// hardware events into the bank
	input wire logic [3:0] reset_cause_set_i,
	input wire logic wdog_flag_set_i,
	input wire logic spm_busy_i,
	// register contents to the rest of the chip
	output logic [7:0] sleep_mode_control_o,
	output logic [7:0] reset_cause_flags_o,
	output logic [7:0] core_control_o,
	output logic [7:0] self_program_control_o,
	output logic [7:0] stack_pointer_low_o,
	output logic [7:0] stack_pointer_high_o,
	output logic [7:0] processor_status_o,
	output logic [7:0] watchdog_control_o,
	output logic [7:0] clock_prescale_o,
	output logic [7:0] power_reduction_o,
	output logic [7:0] oscillator_calibration_o,
	output logic [7:0] pin_change_irq_enable_o,
	output logic [7:0] ext_irq_sense_control_o,
	output logic [7:0] pin_change_mask_0_o,
	output logic [7:0] pin_change_mask_1_o,
	output logic [7:0] pin_change_mask_2_o,
	output logic [7:0] timer0_irq_mask_o,
	output logic [7:0] timer1_irq_mask_o,
	output logic [7:0] timer2_irq_mask_o
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	iod_op_e op;
	logic [7:0] acc_addr;
	logic [7:0] acc_wdata;
	logic [7:0] acc_wmask;
	logic [2:0] acc_bit;
	logic test_set;
	logic is_write;
	logic is_read;

	iod_decode u_decode (
		.io_re_i(io_re_i),
		.io_we_i(io_we_i),
		.io_addr_i(io_addr_i),
		.ds_re_i(ds_re_i),
		.ds_we_i(ds_we_i),
		.ds_addr_i(ds_addr_i),
		.wdata_i(wdata_i),
		.bit_set_instr_i(bit_set_instr_i),
		.bit_clear_instr_i(bit_clear_instr_i),
		.skip_if_bit_set_instr_i(skip_if_bit_set_instr_i),
		.skip_if_bit_clear_instr_i(skip_if_bit_clear_instr_i),
		.bit_addr_i(bit_addr_i),
		.bit_sel_i(bit_sel_i),
		.op_o(op),
		.addr_o(acc_addr),
		.wdata_o(acc_wdata),
		.wmask_o(acc_wmask),
		.bit_o(acc_bit),
		.test_set_o(test_set)
	);

	always_comb begin
		is_write = 1'b0;
		is_read = 1'b0;
		case (op)
			IOD_OP_WRITE,
			IOD_OP_BSET,
			IOD_OP_BCLR: begin
				is_write = 1'b1;
			end
			IOD_OP_READ,
			IOD_OP_BTEST: begin
				is_read = 1'b1;
			end
			default: begin
				is_write = 1'b0;
				is_read = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// address match
	// ----------------------------------------
	logic [IOD_NREG-1:0] hit;
	logic local_hit;

	always_comb begin
		for (int i = 0; i < IOD_NREG; i++) begin
			hit[i] = (acc_addr == IOD_REG_OFF[i]);
		end
	end

	assign local_hit = |hit;

	// ----------------------------------------
	// hardware set and read-only inputs
	// ----------------------------------------
	iod_byte_t hw_set [IOD_NREG];
	iod_byte_t ro_val [IOD_NREG];

	always_comb begin
		for (int i = 0; i < IOD_NREG; i++) begin
			hw_set[i] = IOD_ZERO;
			ro_val[i] = IOD_ZERO;
		end
		hw_set[R_RCAUSE][IOD_RCAUSE_W-1:0] = reset_cause_set_i;
		hw_set[R_WDOG][IOD_WDOG_FLAG_BIT] = wdog_flag_set_i;
		ro_val[R_SPM][IOD_SPM_BUSY_BIT] = spm_busy_i;
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	iod_byte_t reg_q [IOD_NREG];

	generate
		for (genvar g = 0; g < IOD_NREG; g++) begin : g_reg
			iod_reg #(
				.WR_MASK(IOD_WR_MASK[g]),
				.W1C_MASK(IOD_W1C_MASK[g]),
				.RO_MASK(IOD_RO_MASK[g]),
				.RST_VAL(IOD_RST_VAL[g])
			) u_reg (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.we_i(is_write && hit[g]),
				.wmask_i(acc_wmask),
				.wdata_i(acc_wdata),
				.hw_set_i(hw_set[g]),
				.ro_val_i(ro_val[g]),
				.q_o(reg_q[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// peripherals outside the bank
	// ----------------------------------------
	// bit ops pass a one-hot mask so flags beside the target stay put
	assign ext_addr_o = acc_addr;
	assign ext_we_o = is_write && !local_hit;
	assign ext_re_o = is_read && !local_hit;
	assign ext_wdata_o = acc_wdata;
	assign ext_wmask_o = acc_wmask;

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = IOD_ZERO;
		for (int i = 0; i < IOD_NREG; i++) begin
			if (hit[i]) begin
				rd_mux = reg_q[i];
			end
		end
		if (!local_hit && ext_hit_i) begin
			rd_mux = ext_rdata_i;
		end
	end

	// ----------------------------------------
	// answers, one cycle after the access
	// ----------------------------------------
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic skip_reg;
	logic skip_valid_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= IOD_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= (op == IOD_OP_READ);
			if (op == IOD_OP_READ) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			skip_reg <= 1'b0;
			skip_valid_reg <= 1'b0;
		end else begin
			skip_valid_reg <= (op == IOD_OP_BTEST);
			if (op == IOD_OP_BTEST) begin
				skip_reg <= (rd_mux[acc_bit] == test_set);
			end
		end
	end

	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign skip_o = skip_reg;
	assign skip_valid_o = skip_valid_reg;

	// ----------------------------------------
	// register contents out
	// ----------------------------------------
	assign sleep_mode_control_o = reg_q[R_SLEEP];
	assign reset_cause_flags_o = reg_q[R_RCAUSE];
	assign core_control_o = reg_q[R_CORE];
	assign self_program_control_o = reg_q[R_SPM];
	assign stack_pointer_low_o = reg_q[R_SPL];
	assign stack_pointer_high_o = reg_q[R_SPH];
	assign processor_status_o = reg_q[R_PROCESSOR_STATUS];
	assign watchdog_control_o = reg_q[R_WDOG];
	assign clock_prescale_o = reg_q[R_CLKPS];
	assign power_reduction_o = reg_q[R_PWR];
	assign oscillator_calibration_o = reg_q[R_OSC];
	assign pin_change_irq_enable_o = reg_q[R_PCIE];
	assign ext_irq_sense_control_o = reg_q[R_EXTSNS];
	assign pin_change_mask_0_o = reg_q[R_PCM0];
	assign pin_change_mask_1_o = reg_q[R_PCM1];
	assign pin_change_mask_2_o = reg_q[R_PCM2];
	assign timer0_irq_mask_o = reg_q[R_TM0];
	assign timer1_irq_mask_o = reg_q[R_TM1];
	assign timer2_irq_mask_o = reg_q[R_TM2];
endmodule : iod_io_space
`default_nettype wire

// >>> verilog/iod_pkg.sv
// iod_pkg: shared constants and types for the I/O space decoder.
// assumes: included before every module of the decoder.
`default_nettype none
package iod_pkg;
	typedef logic [7:0] iod_byte_t;

	// ----------------------------------------
	// address space
	// ----------------------------------------
	localparam int IOD_NREG = 19;
	localparam logic [7:0] IOD_DS_OFFSET = 8'h20;
	localparam logic [5:0] IOD_IO_LAST = 6'h3F;
	localparam logic [4:0] IOD_BIT_LAST = 5'h1F;
	localparam logic [7:0] IOD_EXT_FIRST = 8'h60;
	localparam logic [7:0] IOD_EXT_LAST = 8'hFF;
	localparam logic [7:0] IOD_ZERO = 8'h00;
	localparam logic [7:0] IOD_ONES = 8'hFF;
	localparam logic [7:0] IOD_BIT0 = 8'h01;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int IOD_RCAUSE_W = 4;
	localparam logic [2:0] IOD_WDOG_FLAG_BIT = 3'h7;
	localparam logic [2:0] IOD_SPM_BUSY_BIT = 3'h6;

	typedef enum logic [2:0] {
		IOD_OP_NONE,
		IOD_OP_READ,
		IOD_OP_WRITE,
		IOD_OP_BSET,
		IOD_OP_BCLR,
		IOD_OP_BTEST
	} iod_op_e;

	typedef enum int {
		R_SLEEP, R_RCAUSE, R_CORE, R_SPM, R_SPL, R_SPH, R_PROCESSOR_STATUS, R_WDOG, R_CLKPS, R_PWR,
		R_OSC, R_PCIE, R_EXTSNS, R_PCM0, R_PCM1, R_PCM2, R_TM0, R_TM1, R_TM2
	} iod_reg_e;

	// ----------------------------------------
	// register table, indexed by iod_reg_e
	// ----------------------------------------
	localparam iod_byte_t IOD_REG_OFF [IOD_NREG] = '{8'h53, 8'h54, 8'h55, 8'h57, 8'h5D,
		8'h5E, 8'h5F, 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D,
		8'h6E, 8'h6F, 8'h70};
	localparam iod_byte_t IOD_WR_MASK [IOD_NREG] = '{8'h0F, 8'h0F, 8'h73, 8'hBF, 8'hFF,
		8'h07, 8'hFF, 8'h7F, 8'h8F, 8'hEF, 8'hFF, 8'h07, 8'h0F, 8'hFF, 8'h7F, 8'hFF,
		8'h07, 8'h27, 8'h07};
	localparam iod_byte_t IOD_W1C_MASK [IOD_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam iod_byte_t IOD_RO_MASK [IOD_NREG] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam iod_byte_t IOD_RST_VAL [IOD_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
endpackage : iod_pkg
`default_nettype wire

// >>> verilog/iod_decode.sv
// iod_decode: turns the three core access paths into one data-space access.
// assumes: at most one path requests per cycle; io path wins, then data, then bit.
`timescale 1ns/10ps
`default_nettype none
module iod_decode
	import iod_pkg::*;
(
	input wire logic io_re_i,
	input wire logic io_we_i,
	input wire logic [5:0] io_addr_i,
	input wire logic ds_re_i,
	input wire logic ds_we_i,
	input wire logic [7:0] ds_addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic bit_set_instr_i,
	input wire logic bit_clear_instr_i,
	input wire logic skip_if_bit_set_instr_i,
	input wire logic skip_if_bit_clear_instr_i,
	input wire logic [4:0] bit_addr_i,
	input wire logic [2:0] bit_sel_i,
	output iod_op_e op_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic [7:0] wmask_o,
	output logic [2:0] bit_o,
	output logic test_set_o
);
	always_comb begin
		op_o = IOD_OP_NONE;
		addr_o = IOD_ZERO;
		wdata_o = wdata_i;
		wmask_o = IOD_ZERO;
		bit_o = bit_sel_i;
		test_set_o = skip_if_bit_set_instr_i;
		if (io_re_i || io_we_i) begin
			// 6-bit address covers 0x00..0x3F only, so 0x60 and up is out of reach
			addr_o = {2'b00, io_addr_i} + IOD_DS_OFFSET;
			op_o = io_we_i ? IOD_OP_WRITE : IOD_OP_READ;
			wmask_o = io_we_i ? IOD_ONES : IOD_ZERO;
		end else if (ds_re_i || ds_we_i) begin
			// below the offset lies the working register file, not I/O
			if (ds_addr_i >= IOD_DS_OFFSET) begin
				addr_o = ds_addr_i;
				op_o = ds_we_i ? IOD_OP_WRITE : IOD_OP_READ;
				wmask_o = ds_we_i ? IOD_ONES : IOD_ZERO;
			end
		end else if (bit_set_instr_i || bit_clear_instr_i) begin
			addr_o = {3'b000, bit_addr_i} + IOD_DS_OFFSET;
			op_o = bit_set_instr_i ? IOD_OP_BSET : IOD_OP_BCLR;
			wmask_o = IOD_BIT0 << bit_sel_i;
			wdata_o = bit_set_instr_i ? IOD_ONES : IOD_ZERO;
		end else if (skip_if_bit_set_instr_i || skip_if_bit_clear_instr_i) begin
			addr_o = {3'b000, bit_addr_i} + IOD_DS_OFFSET;
			op_o = IOD_OP_BTEST;
		end
	end
endmodule : iod_decode
`default_nettype wire

// >>> verilog/iod_reg.sv
// iod_reg: one 8-bit I/O register with write mask, one-to-clear and set bits.
// assumes: write strobe and bit mask come from the decoder on the same clock.
`timescale 1ns/10ps
`default_nettype none
module iod_reg
	import iod_pkg::*;
#(
	parameter logic [7:0] WR_MASK = 8'hFF,
	parameter logic [7:0] W1C_MASK = 8'h00,
	parameter logic [7:0] RO_MASK = 8'h00,
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [7:0] wmask_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] hw_set_i,
	input wire logic [7:0] ro_val_i,
	output logic [7:0] q_o
);
	logic [7:0] val_reg;
	logic [7:0] val_next;

	always_comb begin
		val_next = val_reg;
		if (we_i) begin
			val_next = (val_reg & ~(wmask_i & WR_MASK)) | (wdata_i & wmask_i & WR_MASK);
			val_next = val_next & ~(wdata_i & wmask_i & W1C_MASK);
		end
		// a flag raised in the clearing cycle survives
		val_next = val_next | (hw_set_i & ~RO_MASK);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			val_reg <= RST_VAL;
		end else begin
			val_reg <= val_next;
		end
	end

	assign q_o = (val_reg & ~RO_MASK) | (ro_val_i & RO_MASK);
endmodule : iod_reg
`default_nettype wire

// >>> verif/iod_periph_model.sv
// iod_periph_model: peripheral bytes at data 0x20..0x3F behind the ext port.
// assumes: answers in the same cycle; writes land on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module iod_periph_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] ext_addr_i,
	input wire logic ext_we_i,
	input wire logic [7:0] ext_wdata_i,
	input wire logic [7:0] ext_wmask_i,
	output logic ext_hit_o,
	output logic [7:0] ext_rdata_o
);
	logic [7:0] mem_reg [32];
	logic [4:0] idx;
	assign idx = ext_addr_i[4:0];
	assign ext_hit_o = ext_addr_i[7:5] == 3'h1;
	// junk when not selected
	assign ext_rdata_o = ext_hit_o ? mem_reg[idx] : 8'h5A;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) begin
				mem_reg[i] <= 8'h80;
			end
		end else if (ext_we_i && ext_hit_o) begin
			mem_reg[idx] <= {mem_reg[idx][7] & ~(ext_wmask_i[7] & ext_wdata_i[7]),
				(mem_reg[idx][6:0] & ~ext_wmask_i[6:0]) | (ext_wdata_i[6:0] & ext_wmask_i[6:0])};
		end
	end
endmodule : iod_periph_model
`default_nettype wire

// >>> verif/iod_io_space_asserts.sv
// iod_io_space_asserts: port-level checks of the I/O space decoder.
// assumes: bound to iod_io_space; one clock.
`timescale 1ns/10ps
`default_nettype none
module iod_io_space_asserts
	import iod_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic io_re_i,
	input wire logic io_we_i,
	input wire logic [5:0] io_addr_i,
	input wire logic ds_re_i,
	input wire logic ds_we_i,
	input wire logic [7:0] ds_addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic bit_set_instr_i,
	input wire logic bit_clear_instr_i,
	input wire logic skip_if_bit_set_instr_i,
	input wire logic skip_if_bit_clear_instr_i,
	input wire logic [4:0] bit_addr_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic skip_valid_o,
	input wire logic [7:0] ext_addr_o,
	input wire logic ext_re_o,
	input wire logic ext_we_o,
	input wire logic [7:0] ext_wdata_o,
	input wire logic [7:0] ext_wmask_o,
	input wire logic ext_hit_i,
	input wire logic wdog_flag_set_i,
	input wire logic [7:0] sleep_mode_control_o,
	input wire logic [7:0] watchdog_control_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic core;
	logic bop;
	logic tst;
	assign core = io_re_i | io_we_i | ds_re_i | ds_we_i;
	assign bop = !core && (bit_set_instr_i || bit_clear_instr_i);
	assign tst = !core && !bop && (skip_if_bit_set_instr_i || skip_if_bit_clear_instr_i);
	chk_read_answer: assert property (((io_re_i && !io_we_i) || (ds_re_i && !ds_we_i
		&& !io_we_i && ds_addr_i >= IOD_DS_OFFSET)) |=> rvalid_o)
		else $error("read not answered next cycle");
	chk_low_silent: assert property (ds_re_i && !io_re_i && !io_we_i
		&& ds_addr_i < IOD_DS_OFFSET |=> !rvalid_o) else $error("read below offset answered");
	chk_ext_read: assert property (tst |-> ext_re_o)
		else $error("bit test not passed to ext port");
	chk_skip_answer: assert property (tst |=> skip_valid_o)
		else $error("bit test not answered next cycle");
	chk_io_map: assert property (io_re_i || io_we_i |->
		ext_addr_o == {2'h0, io_addr_i} + IOD_DS_OFFSET) else $error("io address not offset");
	chk_io_low: assert property (io_re_i || io_we_i |-> ext_addr_o < IOD_EXT_FIRST)
		else $error("io path reached extended space");
	chk_bit_mask: assert property (bop |-> ext_we_o && ext_addr_o == {3'h1, bit_addr_i}
		&& ext_wmask_o == (8'h01 << bit_sel_i)) else $error("bit op not one-hot");
	chk_bit_data: assert property (bop |->
		ext_wdata_o == (bit_set_instr_i ? 8'hFF : 8'h00)) else $error("bit op data wrong");
	chk_rsvd_zero: assert property (ds_re_i && !io_re_i && !io_we_i && ds_addr_i == 8'h74
		&& !ext_hit_i |=> rdata_o == 8'h00) else $error("reserved read not zero");
	chk_wdog_clear: assert property (ds_we_i && !io_re_i && !io_we_i && wdata_i[7]
		&& ds_addr_i == IOD_EXT_FIRST && !wdog_flag_set_i |=> !watchdog_control_o[7])
		else $error("flag not cleared by one");
	chk_io_write: assert property (io_we_i && io_addr_i == 6'h33 |=>
		sleep_mode_control_o == ($past(wdata_i) & 8'h0F)) else $error("io write lost");
	cov_read: cover property (ds_re_i ##1 rvalid_o);
	cov_bit: cover property (bop);
	cov_test: cover property (tst ##1 skip_valid_o);
endmodule : iod_io_space_asserts
bind iod_io_space iod_io_space_asserts u_iod_io_space_asserts (.*);
`default_nettype wire

// >>> verif/tb_io_space_address_decoder.sv
// tb_io_space_address_decoder: self-checking bench of the I/O space decoder.
// assumes: peripheral model on the ext port, checker bound to the design.
`timescale 1ns/10ps
`default_nettype none
module tb_io_space_address_decoder;
	import iod_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [7:0] stb = 0;
	logic [7:0] addr = 0;
	logic [7:0] wdata = 0;
	logic wdog_flag_set_i = 0;
	logic spm_busy_i = 0;
	logic [3:0] rcause = 4'h0;
	logic [7:0] rdata_o, ext_addr_o, ext_wdata_o, ext_wmask_o, ext_rdata_i, smc, wdc, cc, rcf;
	logic rvalid_o, skip_o, skip_valid_o, ext_we_o, ext_hit_i;
	int n_mismatch = 0;
	int n_compared = 0;
	always #20 clk_i = ~clk_i;
	iod_io_space u_iod_io_space (.clk_i(clk_i), .rst_i(rst_i), .io_we_i(stb[0]),
		.io_re_i(stb[1]), .io_addr_i(addr[5:0]), .ds_we_i(stb[2]), .ds_re_i(stb[3]),
		.ds_addr_i(addr), .wdata_i(wdata), .bit_set_instr_i(stb[4]),
		.bit_clear_instr_i(stb[5]), .skip_if_bit_set_instr_i(stb[6]),
		.skip_if_bit_clear_instr_i(stb[7]), .bit_addr_i(addr[4:0]), .bit_sel_i(wdata[2:0]),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .skip_o(skip_o), .skip_valid_o(skip_valid_o),
		.ext_addr_o(ext_addr_o), .ext_re_o(), .ext_we_o(ext_we_o), .ext_wdata_o(ext_wdata_o),
		.ext_wmask_o(ext_wmask_o), .ext_hit_i(ext_hit_i), .ext_rdata_i(ext_rdata_i),
		.reset_cause_set_i(rcause), .wdog_flag_set_i(wdog_flag_set_i), .spm_busy_i(spm_busy_i),
		.sleep_mode_control_o(smc), .reset_cause_flags_o(rcf), .core_control_o(cc),
		.self_program_control_o(), .stack_pointer_low_o(), .stack_pointer_high_o(),
		.processor_status_o(), .watchdog_control_o(wdc), .clock_prescale_o(),
		.power_reduction_o(), .oscillator_calibration_o(), .pin_change_irq_enable_o(),
		.ext_irq_sense_control_o(), .pin_change_mask_0_o(), .pin_change_mask_1_o(),
		.pin_change_mask_2_o(), .timer0_irq_mask_o(), .timer1_irq_mask_o(),
		.timer2_irq_mask_o());
	iod_periph_model u_iod_periph_model (.clk_i(clk_i), .rst_i(rst_i),
		.ext_addr_i(ext_addr_o), .ext_we_i(ext_we_o), .ext_wdata_i(ext_wdata_o),
		.ext_wmask_i(ext_wmask_o), .ext_hit_o(ext_hit_i), .ext_rdata_o(ext_rdata_i));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// k: 0 io wr, 1 io rd, 2 ds wr, 3 ds rd, 4 set, 5 clear, 6 skip-set, 7 skip-clear
	task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		stb = 8'h01 << k;
		addr = a;
		wdata = d;
		@(posedge clk_i);
		#1;
		stb = 0;
	endtask : acc
	task automatic rd(input int k, input logic [7:0] a, input logic [7:0] exp);
		acc(k, a, 8'h00);
		chk({7'h0, rvalid_o}, 8'h01);
		chk(rdata_o, exp);
	endtask : rd
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	task automatic t_paths();
		chk(smc | cc | wdc, 8'h00);
		acc(0, 8'h33, 8'hFF);
		rd(3, 8'h53, 8'h0F);
		acc(2, 8'h5D, 8'hA5);
		rd(1, 8'h3D, 8'hA5);
		spm_busy_i = 1;
		rd(1, 8'h37, 8'h40);
		spm_busy_i = 0;
		acc(2, 8'h70, 8'hFF);
		rd(3, 8'h70, 8'h07);
		acc(2, 8'h6C, 8'hFF);
		rd(3, 8'h6C, 8'h7F);
		rcause = 4'h5;
		@(posedge clk_i);
		#1 rcause = 4'h0;
		rd(3, 8'h54, 8'h05);
		chk(rcf, 8'h05);
	endtask : t_paths
	task automatic t_rsvd();
		acc(2, 8'h74, 8'hFF);
		rd(3, 8'h74, 8'h00);
		rd(1, 8'h38, 8'h00);
		acc(3, 8'h10, 8'h00);
		chk({7'h0, rvalid_o}, 8'h00);
		chk(rdata_o, 8'h00);
	endtask : t_rsvd
	task automatic t_flag();
		@(posedge clk_i);
		#1 wdog_flag_set_i = 1;
		@(posedge clk_i);
		#1 wdog_flag_set_i = 0;
		rd(3, 8'h60, 8'h80);
		acc(2, 8'h60, 8'h00);
		rd(3, 8'h60, 8'h80);
		acc(2, 8'h60, 8'h80);
		rd(3, 8'h60, 8'h00);
		wdog_flag_set_i = 1;
		acc(2, 8'h60, 8'h80);
		wdog_flag_set_i = 0;
		rd(3, 8'h60, 8'h80);
	endtask : t_flag
	task automatic t_bits();
		acc(4, 8'h05, 8'h02);
		rd(3, 8'h25, 8'h84);
		acc(6, 8'h05, 8'h02);
		chk({skip_valid_o, skip_o}, 8'h03);
		acc(7, 8'h05, 8'h02);
		chk({skip_valid_o, skip_o}, 8'h02);
		acc(5, 8'h05, 8'h02);
		rd(3, 8'h25, 8'h80);
		acc(4, 8'h1F, 8'h00);
		rd(3, 8'h3F, 8'h81);
	endtask : t_bits
	initial begin
		#(40 * 2000);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		#1 rst_i = 0;
		t_paths();
		t_rsvd();
		t_flag();
		t_bits();
		end_sim();
	end
endmodule : tb_io_space_address_decoder
`default_nettype wire
